// ---- hw/pcw_pkg.sv ----
package pcw_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_END_NS      = 405000;
    localparam int WORD_LATCH_TIMEOUT_NS      = 50000;
    localparam int T_ON_MIN_NS   = 1000;
    localparam int T_OFF_MIN_NS  = 1000;
    // Least times, rounded up to whole cycles
    localparam int END_CYC       = (T_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LAT_CYC       = (WORD_LATCH_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TON_CYC       = (T_ON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOFF_CYC      = (T_OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W         = 13;
    localparam logic [TMR_W-1:0] END_CNT  = TMR_W'(END_CYC);
    localparam logic [TMR_W-1:0] LAT_CNT  = TMR_W'(LAT_CYC);
    localparam logic [TMR_W-1:0] TON_CNT  = TMR_W'(TON_CYC);
    localparam logic [TMR_W-1:0] TOFF_CNT = TMR_W'(TOFF_CYC);

    // ==========================================================
    // Word counter and register map
    // ==========================================================
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_SAT          = 6'h3f;
    localparam logic [CNT_W-1:0] ADDR_FLASH       = 6'h01;
    localparam logic [CNT_W-1:0] ADDR_TORCH       = 6'h02;
    localparam logic [CNT_W-1:0] ADDR_TMR_LEN     = 6'h03;
    localparam logic [CNT_W-1:0] ADDR_BATT        = 6'h04;
    localparam logic [CNT_W-1:0] ADDR_TMR_LVL     = 6'h05;
    localparam logic [CNT_W-1:0] MAX_FLASH        = 6'h1f;
    localparam logic [CNT_W-1:0] MAX_TORCH        = 6'h1f;
    localparam logic [CNT_W-1:0] MAX_TMR_LEN      = 6'h07;
    localparam logic [CNT_W-1:0] MAX_BATT         = 6'h09;
    localparam logic [CNT_W-1:0] MAX_TMR_LVL      = 6'h05;
    localparam int               EN_BIT           = 4;
    localparam logic [1:0]       WORDS_PER_FRAME  = 2'h2;
    localparam logic [1:0]       WORDS_SAT        = 2'h3;

    typedef struct packed {
        logic [4:0] flash_enable_and_level;
        logic [4:0] torch_enable_and_level;
        logic [2:0] safety_timer_length;
        logic [3:0] battery_low_threshold;
        logic [2:0] safety_timer_current_level;
    } pcw_regs_t;

    localparam pcw_regs_t REGS_RST = '{5'h04, 5'h04, 3'h7, 4'h1, 3'h4};

    // ==========================================================
    // Current decode
    // ==========================================================
    localparam logic [3:0]  LAST_LINEAR_CODE = 4'hd;
    localparam logic [10:0] FLASH_MA_BASE    = 11'h4b0;
    localparam logic [10:0] FLASH_MA_STEP    = 11'h032;
    localparam logic [10:0] FLASH_MA_CODE14  = 11'h190;
    localparam logic [10:0] FLASH_MA_CODE15  = 11'h0fa;
    localparam logic [11:0] TORCH_DMA_BASE   = 12'hbb8;
    localparam logic [11:0] TORCH_DMA_STEP   = 12'h07d;
    localparam logic [11:0] TORCH_DMA_CODE14 = 12'h3e8;
    localparam logic [11:0] TORCH_DMA_CODE15 = 12'h271;

    typedef enum logic [2:0] {
        ST_SHUT = 3'b000,
        ST_IDLE = 3'b001,
        ST_LOW  = 3'b011,
        ST_HIGH = 3'b010,
        ST_ERR  = 3'b110
    } pcw_state_t;

endpackage

// ---- hw/pcw_port.sv ----
`timescale 1ns/10ps

// Function
// - High for end period after frame, rise in shutdown, or error: go idle, keep registers.
// - Low for end period: shutdown, drop frame, registers to defaults.
// - Low longer than latch timeout but short of shutdown: discard frame as error.
// - Pulse count above the addressed register's maximum: data discarded.
// - First falling edge in idle starts frame; first rising edge clears counter.
// - Count pulse only if low then rise within latch timeout; short lows are not counted, short highs end the frame in error.
// - Every counted rising edge after the first in a word increments the word counter.
// - High beyond latch timeout latches word: first to address, second to data shadow.
// - Stop after frame starts decode and update of the selected register.
// - Only exactly one address and one data word accepted; others discarded.
// - Addresses start at 1; bad address or oversize data discards frame.
// - Five write-only registers at 1..5, maxima 31, 31, 7, 9, 5.
// - Flash register bit 4 enables flash, bits 3:0 select current.
// - Flash code: 1200 mA down 50 mA per step to 13; 400, 250 mA.
// - Torch register bit 4 enables torch, bits 3:0 select current; here bit 4 is only stored, and no logic uses it.
// - Torch code: 300 mA down 12.5 mA per step; 100, 62.5 mA.
// - Flash register defaults to 4 after shutdown: 1 A, not enabled.
// - Safety timer length codes 0..7, default 7, limit LED on-time; here the code is only stored, and flash_active_o has no time limit.
// - Shutdown period is 405 us of low line.
// - Flash trigger rise starts flash mode; ends when pin low and enable clear.
module pcw_port
    import pcw_pkg::*;
#(
    parameter logic [TMR_W-1:0] END_LIMIT  = END_CNT,
    parameter logic [TMR_W-1:0] LAT_LIMIT  = LAT_CNT,
    parameter logic [TMR_W-1:0] TON_LIMIT  = TON_CNT,
    parameter logic [TMR_W-1:0] TOFF_LIMIT = TOFF_CNT
)
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // Pins
    input  wire logic        control_line_i,
    input  wire logic        flash_trigger_i,
    // Register contents
    output pcw_regs_t        ctrl_regs_o,
    // Decoded currents, flash in mA, torch in 0.1 mA
    output logic [10:0]      flash_current_ma_o,
    output logic [11:0]      torch_current_dma_o,
    // Status
    output logic             shutdown_o,
    output logic             flash_active_o,
    output logic             write_done_o,
    output logic             frame_error_o
);

    // ==========================================================
    // Line synchroniser and period timer
    // ==========================================================
    logic              sync_meta;
    logic              sync_line;
    logic              line_q;
    logic              rise;
    logic              fall;
    logic [TMR_W-1:0]  tmr;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            sync_meta <= 1'b0;
            sync_line <= 1'b0;
            line_q    <= 1'b0;
        end
        else
        begin
            sync_meta <= control_line_i;
            sync_line <= sync_meta;
            line_q    <= sync_line;
        end
    end

    assign rise = sync_line & ~line_q;
    assign fall = ~sync_line & line_q;

    // Saturates at the end period so a parked line never wraps back to zero
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            tmr <= '0;
        else if (rise | fall)
            tmr <= '0;
        else if (tmr != END_LIMIT)
            tmr <= tmr + 13'h0001;
    end

    // ==========================================================
    // Frame state machine
    // ==========================================================
    pcw_state_t        state;
    pcw_state_t        next_state;
    logic              go_shut;
    logic              count_pulse;
    logic              latch_word;
    logic              stop;
    logic              to_err;
    logic              word_first;
    logic              frame_ok;
    logic              do_write;
    logic [CNT_W-1:0]  pulse_cnt;
    logic [CNT_W-1:0]  addr_sh;
    logic [CNT_W-1:0]  data_sh;
    logic [1:0]        words;

    function automatic logic [CNT_W-1:0] reg_max(input logic [CNT_W-1:0] a);
        case (a)
            ADDR_FLASH:   reg_max = MAX_FLASH;
            ADDR_TORCH:   reg_max = MAX_TORCH;
            ADDR_TMR_LEN: reg_max = MAX_TMR_LEN;
            ADDR_BATT:    reg_max = MAX_BATT;
            ADDR_TMR_LVL: reg_max = MAX_TMR_LVL;
            default:      reg_max = '0;
        endcase
    endfunction

    // A rise in the same cycle as the end count means the line is already back
    assign go_shut = ~line_q & ~rise & (tmr == END_LIMIT);

    always_comb
    begin
        next_state  = state;
        count_pulse = 1'b0;
        latch_word  = 1'b0;
        stop        = 1'b0;
        to_err      = 1'b0;
        if (go_shut)
            next_state = ST_SHUT;
        else
        begin
            case (state)
                ST_SHUT:
                    if (rise)
                        next_state = ST_IDLE;
                ST_IDLE:
                    if (fall)
                        next_state = ST_LOW;
                ST_LOW:
                    if (rise)
                    begin
                        next_state  = ST_HIGH;
                        count_pulse = (tmr >= TOFF_LIMIT);
                    end
                    else if (tmr == LAT_LIMIT)
                    begin
                        next_state = ST_ERR;
                        to_err     = 1'b1;
                    end
                ST_HIGH:
                    if (fall)
                    begin
                        next_state = (tmr < TON_LIMIT) ? ST_ERR : ST_LOW;
                        to_err     = (tmr < TON_LIMIT);
                    end
                    else if (tmr == LAT_LIMIT)
                        latch_word = ~word_first;
                    else if (tmr == END_LIMIT)
                    begin
                        next_state = ST_IDLE;
                        stop       = 1'b1;
                    end
                ST_ERR:
                    if (rise)
                        next_state = ST_IDLE;
                default:
                    next_state = ST_SHUT;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            state <= ST_SHUT;
        else
            state <= next_state;
    end

    // ==========================================================
    // Word counting and shadows
    // ==========================================================
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i || (state == ST_IDLE && fall))
        begin
            word_first <= 1'b1;
            pulse_cnt  <= '0;
            words      <= '0;
        end
        else if (count_pulse)
        begin
            word_first <= 1'b0;
            if (word_first)
                pulse_cnt <= '0;
            else if (pulse_cnt != CNT_SAT)
                pulse_cnt <= pulse_cnt + 6'h01;
        end
        else if (latch_word)
        begin
            word_first <= 1'b1;
            if (words != WORDS_SAT)
                words <= words + 2'h1;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            addr_sh <= '0;
            data_sh <= '0;
        end
        else if (latch_word && words == 2'h0)
            addr_sh <= pulse_cnt;
        else if (latch_word && words == 2'h1)
            data_sh <= pulse_cnt;
    end

    // Saturated count reads 63, above every maximum, so overflow is caught here too
    assign frame_ok = (words == WORDS_PER_FRAME)
                    && (reg_max(addr_sh) != '0)
                    && (data_sh <= reg_max(addr_sh));
    assign do_write = stop & frame_ok;

    // ==========================================================
    // Control registers
    // ==========================================================
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i || go_shut)
            ctrl_regs_o <= REGS_RST;
        else if (do_write)
        begin
            case (addr_sh)
                ADDR_FLASH:   ctrl_regs_o.flash_enable_and_level     <= data_sh[4:0];
                ADDR_TORCH:   ctrl_regs_o.torch_enable_and_level     <= data_sh[4:0];
                ADDR_TMR_LEN: ctrl_regs_o.safety_timer_length        <= data_sh[2:0];
                ADDR_BATT:    ctrl_regs_o.battery_low_threshold      <= data_sh[3:0];
                ADDR_TMR_LVL: ctrl_regs_o.safety_timer_current_level <= data_sh[2:0];
                default:      ctrl_regs_o <= ctrl_regs_o;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            shutdown_o    <= 1'b1;
            write_done_o  <= 1'b0;
            frame_error_o <= 1'b0;
        end
        else
        begin
            shutdown_o    <= (next_state == ST_SHUT);
            write_done_o  <= do_write;
            frame_error_o <= to_err | (stop & ~frame_ok);
        end
    end

    // ==========================================================
    // Current decode, one cycle behind the registers
    // ==========================================================
    logic [3:0] fcode;
    logic [3:0] tcode;

    assign fcode = ctrl_regs_o.flash_enable_and_level[3:0];
    assign tcode = ctrl_regs_o.torch_enable_and_level[3:0];

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            flash_current_ma_o  <= '0;
            torch_current_dma_o <= '0;
        end
        else
        begin
            if (fcode <= LAST_LINEAR_CODE)
                flash_current_ma_o <= FLASH_MA_BASE - FLASH_MA_STEP * {7'h00, fcode};
            else
                flash_current_ma_o <= fcode[0] ? FLASH_MA_CODE15 : FLASH_MA_CODE14;
            if (tcode <= LAST_LINEAR_CODE)
                torch_current_dma_o <= TORCH_DMA_BASE - TORCH_DMA_STEP * {8'h00, tcode};
            else
                torch_current_dma_o <= tcode[0] ? TORCH_DMA_CODE15 : TORCH_DMA_CODE14;
        end
    end

    // ==========================================================
    // Flash mode
    // ==========================================================
    logic trig_q;
    logic flash_en;

    assign flash_en = ctrl_regs_o.flash_enable_and_level[EN_BIT];

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            trig_q         <= 1'b0;
            flash_active_o <= 1'b0;
        end
        else
        begin
            trig_q <= flash_trigger_i;
            // Flash mode is off in shutdown, whatever the pin does
            if (state == ST_SHUT)
                flash_active_o <= 1'b0;
            else if ((flash_trigger_i & ~trig_q) | flash_en)
                flash_active_o <= 1'b1;
            else if (!flash_trigger_i)
                flash_active_o <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    shut_entry_a: assert property (go_shut |=> shutdown_o && ctrl_regs_o == REGS_RST)
        else $error("long low did not shut down and reset registers");
    shut_wake_a: assert property (state == ST_SHUT && rise && !go_shut |=> state == ST_IDLE && !shutdown_o)
        else $error("rise in shutdown did not reach idle");
    lat_error_a: assert property (state == ST_LOW && !rise && tmr == LAT_LIMIT |=> state == ST_ERR ##0 frame_error_o)
        else $error("late low not turned into error");
    pulse_inc_a: assert property (count_pulse && !word_first && pulse_cnt != CNT_SAT
                                  |=> pulse_cnt == $past(pulse_cnt) + 6'h01)
        else $error("counted pulse did not increment");
    first_clear_a: assert property (count_pulse && word_first |=> pulse_cnt == '0 && !word_first)
        else $error("first rise did not clear counter");
    glitch_a: assert property (state == ST_LOW && rise && tmr < TOFF_LIMIT |=> $stable(pulse_cnt))
        else $error("short low was counted");
    addr_latch_a: assert property (latch_word && words == 2'h0 |=> addr_sh == $past(pulse_cnt) ##1 word_first)
        else $error("address word not latched");
    reject_a: assert property (stop && words != WORDS_PER_FRAME |=> !write_done_o && frame_error_o
                               && $stable(ctrl_regs_o))
        else $error("malformed frame changed registers");
    no_stray_a: assert property (!$stable(ctrl_regs_o) |-> $past(do_write) || $past(go_shut))
        else $error("register changed without a valid frame");
    flash_on_a: assert property (state != ST_SHUT && flash_trigger_i && !trig_q |=> flash_active_o)
        else $error("trigger rise did not start flash mode");

    write_c: cover property (write_done_o);
    shutdown_c: cover property (go_shut ##1 shutdown_o);
    error_c: cover property (state == ST_ERR);
    bad_data_c: cover property (stop && words == WORDS_PER_FRAME && !frame_ok);

endmodule

// ---- dv/pcw_host.sv ----
`timescale 1ns/10ps

// ==========================================
// Host GPIO model driving the control line
// ==========================================
module pcw_host
#(
    parameter int LAT = 40,
    parameter int END = 200
)
(
    // Clock
    input  wire logic ref_clk_i,
    // Line
    output logic      control_line_o
);
    initial control_line_o = 1'b0;

    // The GPIO always drives, so the line never floats
    task automatic level(input logic v, input int n);
        @(negedge ref_clk_i);
        control_line_o = v;
        repeat (n - 1) @(negedge ref_clk_i);
    endtask

    // Value v takes v+1 pulses; 5-cycle phases clear the glitch filter
    task automatic word(input int v, input bit glitch);
        for (int i = 0; i <= v; i++)
        begin
            level(1'b0, 5);
            level(1'b1, 5);
            if (glitch && i == 0)
            begin
                level(1'b0, 2);
                level(1'b1, 5);
            end
        end
        level(1'b1, LAT + 20);
    endtask

    task automatic stop();
        level(1'b1, END + 20);
    endtask
endmodule

// ---- dv/pcw_port_test.sv ----
`timescale 1ns/10ps

// ==========================================
// Pulse-count port bench
// ==========================================
module pcw_port_test import pcw_pkg::*;;
    localparam int LAT = 40;
    localparam int END = 200;
    localparam logic [1:0] K_WR = 2'h0;
    localparam logic [1:0] K_ERR = 2'h1;
    localparam logic [1:0] K_SHUT = 2'h2;
    localparam pcw_regs_t DEF = '{5'h04, 5'h04, 3'h7, 4'h1, 3'h4};
    typedef struct packed {logic [1:0] kind; pcw_regs_t regs;} pcw_note_t;

    logic        ref_clk_i;
    logic        rst_n_i;
    logic        control_line_i;
    logic        flash_trigger_i;
    pcw_regs_t   ctrl_regs_o;
    logic [10:0] flash_current_ma_o;
    logic [11:0] torch_current_dma_o;
    logic        shutdown_o;
    logic        flash_active_o;
    logic        write_done_o;
    logic        frame_error_o;
    int          fail_count;
    int          n_checks;
    logic [31:0] rng;
    pcw_regs_t   exp_regs;
    pcw_note_t   notes[$];
    pcw_note_t   exp_n;
    logic [1:0]  got_k;
    logic        prev_shut;
    int          mx[6] = '{0, 31, 31, 7, 9, 5};

    initial
    begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Short counts keep the run brief
    pcw_port #(.END_LIMIT(13'h0c8), .LAT_LIMIT(13'h028), .TON_LIMIT(13'h003), .TOFF_LIMIT(13'h003)) u_pcw_port
    (
        .ref_clk_i          (ref_clk_i),
        .rst_n_i            (rst_n_i),
        .control_line_i     (control_line_i),
        .flash_trigger_i    (flash_trigger_i),
        .ctrl_regs_o        (ctrl_regs_o),
        .flash_current_ma_o (flash_current_ma_o),
        .torch_current_dma_o(torch_current_dma_o),
        .shutdown_o         (shutdown_o),
        .flash_active_o     (flash_active_o),
        .write_done_o       (write_done_o),
        .frame_error_o      (frame_error_o)
    );

    pcw_host #(.LAT(LAT), .END(END)) u_pcw_host
    (
        .ref_clk_i     (ref_clk_i),
        .control_line_o(control_line_i)
    );

    // ==========================================
    // Helpers
    // ==========================================
    function automatic logic [31:0] rand32();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic logic [11:0] fl_ma(input logic [3:0] c);
        if (c == 4'he) return 12'h190;
        if (c == 4'hf) return 12'h0fa;
        return 12'h4b0 - 12'h032 * {8'h00, c};
    endfunction

    function automatic logic [11:0] tr_dma(input logic [3:0] c);
        if (c == 4'he) return 12'h3e8;
        if (c == 4'hf) return 12'h271;
        return 12'hbb8 - 12'h07d * {8'h00, c};
    endfunction

    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp);
        report({30'h0, got}, {30'h0, exp});
    endtask

    task automatic cmp_regs(input pcw_regs_t got, input pcw_regs_t exp);
        report({12'h0, got}, {12'h0, exp});
    endtask

    task automatic cmp_cur(input logic [11:0] got, input logic [11:0] exp);
        report({20'h0, got}, {20'h0, exp});
    endtask

    task automatic note(input logic [1:0] k);
        notes.push_back('{k, exp_regs});
    endtask

    // Invalid frames leave the expected registers alone
    task automatic frame(input int a, input int d, input bit g);
        if (a >= 1 && a <= 5 && d <= mx[a])
        begin
            case (a)
                1: exp_regs.flash_enable_and_level = 5'(d);
                2: exp_regs.torch_enable_and_level = 5'(d);
                3: exp_regs.safety_timer_length = 3'(d);
                4: exp_regs.battery_low_threshold = 4'(d);
                default: exp_regs.safety_timer_current_level = 3'(d);
            endcase
            note(K_WR);
        end
        else
            note(K_ERR);
        u_pcw_host.word(a, 1'b0);
        u_pcw_host.word(d, g);
        u_pcw_host.stop();
    endtask

    task automatic results();
        if (fail_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================
    // Result watcher
    // ==========================================
    always @(negedge ref_clk_i)
    begin
        if (rst_n_i !== 1'b1)
            prev_shut = 1'b1;
        else if (write_done_o === 1'b1 || frame_error_o === 1'b1 || (shutdown_o === 1'b1 && !prev_shut))
        begin
            got_k = write_done_o ? K_WR : (frame_error_o ? K_ERR : K_SHUT);
            exp_n = notes.size() > 0 ? notes.pop_front() : '1;
            prev_shut = shutdown_o;
            cmp_flag(got_k, exp_n.kind);
            cmp_regs(ctrl_regs_o, exp_n.regs);
            if (got_k != K_ERR)
            begin
                @(negedge ref_clk_i);
                cmp_cur({1'b0, flash_current_ma_o}, fl_ma(exp_n.regs.flash_enable_and_level[3:0]));
                cmp_cur(torch_current_dma_o, tr_dma(exp_n.regs.torch_enable_and_level[3:0]));
            end
        end
        else
            prev_shut = shutdown_o;
    end

    initial
    begin
        repeat (90000) @(posedge ref_clk_i);
        fail_count++;
        results();
    end

    // ==========================================
    // Scenarios
    // ==========================================
    initial
    begin
        rst_n_i = 1'b0;
        flash_trigger_i = 1'b0;
        rng = 32'hae6005e6;
        fail_count = 0;
        n_checks = 0;
        exp_regs = DEF;
        repeat (20) @(negedge ref_clk_i);
        cmp_regs(ctrl_regs_o, DEF);
        rst_n_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        cmp_cur({1'b0, flash_current_ma_o}, 12'h3e8);
        cmp_flag({1'b0, shutdown_o}, 2'h1);
        u_pcw_host.level(1'b1, 10);
        cmp_flag({1'b0, shutdown_o}, 2'h0);
        for (int i = 0; i < 16; i++)
        begin
            rng = rand32();
            frame(1, i + 16 * rng[0], 1'b0);
            frame(2, 15 - i + 16 * rng[1], 1'b0);
        end
        // Every value up to one past each maximum of registers 3 to 5
        for (int a = 3; a <= 5; a++)
            for (int d = 0; d <= mx[a] + 1; d++)
                frame(a, d, 1'b0);
        frame(1, 32, 1'b0);
        frame(0, 1, 1'b0);
        frame(6, 0, 1'b0);
        frame(3, 4, 1'b1);
        note(K_ERR);
        u_pcw_host.word(2, 1'b0);
        u_pcw_host.stop();
        note(K_ERR);
        repeat (3) u_pcw_host.word(1, 1'b0);
        u_pcw_host.stop();
        note(K_ERR);
        u_pcw_host.level(1'b0, LAT + 10);
        u_pcw_host.level(1'b1, 20);
        cmp_flag({1'b0, shutdown_o}, 2'h0);
        // Abandoned frame: late-low error first, then shutdown
        note(K_ERR);
        exp_regs = DEF;
        note(K_SHUT);
        u_pcw_host.word(2, 1'b0);
        u_pcw_host.level(1'b0, END + 20);
        u_pcw_host.level(1'b1, 20);
        cmp_flag({1'b0, shutdown_o}, 2'h0);
        flash_trigger_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        cmp_flag({1'b0, flash_active_o}, 2'h1);
        flash_trigger_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        cmp_flag({1'b0, flash_active_o}, 2'h0);
        frame(1, 19, 1'b0);
        cmp_flag({1'b0, flash_active_o}, 2'h1);
        frame(1, 3, 1'b0);
        cmp_flag({1'b0, flash_active_o}, 2'h0);
        cmp_flag({1'b0, notes.size() == 0}, 2'h1);
        results();
    end
endmodule
